// *** hdl/vrs_pkg.sv ***
// Shared constants and types of the reference sequencer.
package vrs_pkg;

  // ------------------------------------------------------------
  // Code decoding (reference held in 12.5mV units)
  // ------------------------------------------------------------
  localparam logic [5:0] NOLOAD_A     = 6'h3F;
  localparam logic [5:0] NOLOAD_B     = 6'h3E;
  localparam logic [5:0] DEC_SPLIT    = 6'h14;
  localparam logic [7:0] DEC_BASE_LO  = 8'h57;
  localparam logic [7:0] DEC_BASE_HI  = 8'h95;

  // ------------------------------------------------------------
  // Timing in switching cycles
  // ------------------------------------------------------------
  localparam int         CYC_W           = 11;
  localparam logic [10:0] DELAY_CYC      = 11'h040;
  localparam logic [10:0] COARSE_CYC     = 11'h280;
  localparam logic [10:0] NOLOAD_CYC     = 11'h002;
  localparam logic [10:0] CNT_MAX        = 11'h7FF;
  localparam logic [5:0] COARSE_STEP_CYC = 6'h20;
  localparam logic [5:0] FINE_STEP_CYC   = 6'h10;
  localparam logic [7:0] COARSE_INC      = 8'h02;
  localparam logic [7:0] FINE_INC        = 8'h01;
  localparam logic [3:0] OFS_INIT        = 4'h8;
  localparam logic [6:0] OFS_STEP_CYC    = 7'h50;
  localparam logic [1:0] HALF_WAIT       = 2'h3;
  localparam logic [2:0] PHASE_LAST      = 3'h5;
  localparam logic [15:0] SUB_DIV_DEF    = 16'h002A;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_DIV   = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;

  typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_NOLOAD} vrs_state_type;

endpackage

// *** hdl/vrs_tick_if.sv ***
// Carrier for the switching-cycle strobes between sequencer and timebase.
`timescale 1ns/10ps
interface vrs_tick_if;
  logic [15:0] sub_div;
  logic        sub_tick;
  logic        cyc_tick;

  modport gen (input sub_div, output sub_tick, output cyc_tick);
  modport use_side (output sub_div, input sub_tick, input cyc_tick);
endinterface

// *** hdl/vrs_timebase.sv ***
// Switching-cycle strobe and six-per-cycle sub-strobe generator.
`timescale 1ns/10ps
module vrs_timebase
(
  input  logic      hclk,
  input  logic      hresetn,
  vrs_tick_if.gen   tk
);
  import vrs_pkg::*;

  logic [15:0] div_cnt_r;
  logic [2:0]  phase_r;
  logic        sub_r;
  logic        cyc_r;

  // A divisor of zero behaves as one so the strobes never stop.
  wire logic [15:0] div_end = (tk.sub_div == 16'h0000) ? 16'h0000 : tk.sub_div - 16'h0001;
  wire logic        div_hit = (div_cnt_r >= div_end);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_r <= 16'h0000;
      phase_r   <= 3'h0;
      sub_r     <= 1'b0;
      cyc_r     <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_hit ? 16'h0000 : div_cnt_r + 16'h0001;
      sub_r     <= div_hit; // see R24
      cyc_r     <= div_hit && (phase_r == PHASE_LAST); // see R24
      if (div_hit)
        phase_r <= (phase_r == PHASE_LAST) ? 3'h0 : phase_r + 3'h1;
    end
  end

  assign tk.sub_tick = sub_r;
  assign tk.cyc_tick = cyc_r;

  chk_cycle_on_sub: assert property (@(posedge hclk) disable iff (!hresetn) // see R24
    tk.cyc_tick |-> tk.sub_tick)
    else $error("Cycle strobe without sub-strobe.");

  chk_sub_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // see R01
    (tk.sub_tick && tk.sub_div > 16'h0001 && $stable(tk.sub_div)) |=> !tk.sub_tick)
    else $error("Sub-strobes closer than the divisor allows.");

endmodule

// *** hdl/vrs_sequencer.sv ***
// Reference sequencer: enable gating, soft-start ramp, code tracking, AHB-Lite registers.
//
// Notes on behaviour
// R01: Sample the code six times per cycle.
// R02: On change, wait half cycle, step once.
// R03: Skip step if difference sign reverses.
// R04: Large difference: step six times per cycle.
// R05: Processor should change code one step.
// R06: Shutdown holds PWM outputs high-impedance.
// R07: Stay off until supply valid.
// R08: Stay off until threshold enable high.
// R09: Stay off unless logic enable high.
// R10: No-load codes keep the device off.
// R11: No-load enters shutdown; other code restarts.
// R12: Two cycles after no-load, then shut down.
// R13: No-load codes never clear overvoltage latch.
// R14: Start soft-start at once when enabled.
// R15: Ramp reference from zero to target.
// R16: Keep PWM off until reference reaches output.
// R17: Soft-start opens with 64 idle cycles.
// R18: Ramp takes 1280 cycles per volt.
// R19: First 640 ramp cycles use double steps.
// R20: Sense offset starts 100mV, zero by 640.
// R21: Output ok after soft-start inside window.
// R22: Decode six-bit code to 12.5mV levels.
// R23: Output ok low throughout shutdown.
// R24: Derive cycle strobe and six sub-strobes.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module vrs_sequencer
#(
  parameter logic [15:0] SUB_DIV_RST = vrs_pkg::SUB_DIV_DEF
)
(
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  input  logic        supply_valid_flag,
  input  logic        threshold_enable_input,
  input  logic        logic_level_enable,
  input  logic [5:0]  voltage_id_code,
  input  logic        output_reached,
  input  logic        output_in_window,
  input  logic        ov_trip_event,
  output logic        pwm_hiz,
  output logic [7:0]  ref_level,
  output logic [3:0]  sense_offset,
  output logic        ov_shutdown_level,
  output logic        output_ok_flag
);
  import vrs_pkg::*;

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic vrs_is_noload(input logic [5:0] code);
    return (code == NOLOAD_A) || (code == NOLOAD_B);
  endfunction

  // The code table runs downward in two segments; bit 0 is the half step.
  function automatic logic [7:0] vrs_decode(input logic [5:0] code);
    logic [7:0] c;
    c = {2'h0, code};
    if (code <= DEC_SPLIT)
      return DEC_BASE_LO - c;
    else
      return DEC_BASE_HI - c;
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  vrs_state_type     state_r;
  vrs_state_type     state_nxt;
  logic [10:0]       cnt_r;
  logic [5:0]        step_cnt_r;
  logic [6:0]        ofs_cnt_r;
  logic [3:0]        ofs_r;
  logic [7:0]        ref_r;
  logic              hiz_r;
  logic              output_ok_flag_r;
  logic              ovsd_r;
  logic              ovl_r;
  logic [5:0]        vid_last_r;
  logic [1:0]        wait_r;
  logic              dir_up_r;
  logic              slew_r;
  logic [15:0]       sub_div_r;
  logic              wr_pend_r;
  logic [7:0]        wr_addr_r;
  logic [31:0]       hrdata_r;

  vrs_tick_if tk();

  vrs_timebase u_timebase
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk)
  );

  assign tk.sub_div = sub_div_r;

  // ------------------------------------------------------------
  // Enable gating and code decode
  // ------------------------------------------------------------
  wire logic       pins_ok   = supply_valid_flag & threshold_enable_input
                               & logic_level_enable;
  wire logic       enable_ok = pins_ok & ~ovl_r; // see R07 see R08 see R09 see R13
  wire logic       no_load   = vrs_is_noload(voltage_id_code); // see R10
  wire logic [7:0] target    = vrs_decode(voltage_id_code); // see R22
  wire logic       diff_up   = (target > ref_r);
  wire logic       diff_dn   = (target < ref_r);
  wire logic       same_dir  = dir_up_r ? diff_up : diff_dn;

  // ------------------------------------------------------------
  // Soft-start ramp arithmetic
  // ------------------------------------------------------------
  wire logic       coarse    = (cnt_r < COARSE_CYC); // see R19
  wire logic [5:0] step_per  = coarse ? COARSE_STEP_CYC : FINE_STEP_CYC; // see R18
  wire logic [7:0] ramp_inc  = coarse ? COARSE_INC : FINE_INC;
  wire logic       step_due  = tk.cyc_tick && (step_cnt_r == step_per - 6'h01);
  wire logic [8:0] ramp_sum  = {1'b0, ref_r} + {1'b0, ramp_inc};
  // Clamp so a coarse step never overshoots an odd target.
  wire logic [7:0] ramp_nxt  = (ramp_sum > {1'b0, target}) ? target : ramp_sum[7:0];
  wire logic       ofs_due   = tk.cyc_tick && (ofs_cnt_r == OFS_STEP_CYC - 7'h01);

  // ------------------------------------------------------------
  // Code tracking in regulation
  // ------------------------------------------------------------
  wire logic vid_change = tk.sub_tick && (voltage_id_code != vid_last_r); // see R01
  // A step fires as the half-cycle wait expires, or on every sub-strobe while slewing.
  wire logic dvid_step  = (state_r == ST_RUN) && tk.sub_tick && !vid_change && same_dir
                          && ((wait_r == 2'h1) || ((wait_r == 2'h0) && slew_r)); // see R02 see R03

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:
        if (enable_ok && !no_load)
          state_nxt = ST_DELAY; // see R14 see R11
      ST_DELAY:
        if (tk.cyc_tick && (cnt_r == DELAY_CYC - 11'h001))
          state_nxt = ST_RAMP; // see R17
      ST_RAMP:
        if (ref_r >= target)
          state_nxt = ST_RUN;
      ST_NOLOAD:
        if (tk.cyc_tick && (cnt_r == NOLOAD_CYC - 11'h001))
          state_nxt = ST_OFF; // see R12
      default:
        state_nxt = state_r;
    endcase
    if ((state_r != ST_OFF) && !enable_ok)
      state_nxt = ST_OFF;
    else if ((state_r != ST_OFF) && (state_r != ST_NOLOAD) && no_load)
      state_nxt = ST_NOLOAD; // see R11
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  // Cycle counter restarts on every state change and saturates in a long ramp.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= 11'h000;
    else if (state_nxt != state_r)
      cnt_r <= 11'h000;
    else if (tk.cyc_tick && (cnt_r != CNT_MAX))
      cnt_r <= cnt_r + 11'h001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      step_cnt_r <= 6'h00;
    else if (state_r != ST_RAMP)
      step_cnt_r <= 6'h00;
    else if (tk.cyc_tick)
      step_cnt_r <= step_due ? 6'h00 : step_cnt_r + 6'h01;
  end

  // ------------------------------------------------------------
  // Reference level
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ref_r <= 8'h00;
    else if ((state_r == ST_OFF) || (state_r == ST_DELAY))
      ref_r <= 8'h00; // see R15
    else if ((state_r == ST_RAMP) && step_due && diff_up)
      ref_r <= ramp_nxt; // see R18 see R19
    else if (dvid_step)
      ref_r <= dir_up_r ? ref_r + 8'h01 : ref_r - 8'h01; // see R02 see R04
  end

  // ------------------------------------------------------------
  // Remote-sense offset decay
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ofs_r     <= 4'h0;
      ofs_cnt_r <= 7'h00;
    end
    else if (state_r == ST_DELAY)
    begin
      ofs_r     <= OFS_INIT; // see R20
      ofs_cnt_r <= 7'h00;
    end
    else if (state_r != ST_RAMP)
    begin
      ofs_r     <= 4'h0;
      ofs_cnt_r <= 7'h00;
    end
    else if (tk.cyc_tick)
    begin
      ofs_cnt_r <= ofs_due ? 7'h00 : ofs_cnt_r + 7'h01;
      if (ofs_due && (ofs_r != 4'h0))
        ofs_r <= ofs_r - 4'h1; // see R20
    end
  end

  // ------------------------------------------------------------
  // Code-change tracker
  // ------------------------------------------------------------
  // Any new code whose level differs from the reference restarts the half-cycle wait, so a processor that keeps
  // moving faster than half a cycle only gets steps once it settles.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vid_last_r <= 6'h00;
      wait_r     <= 2'h0;
      dir_up_r   <= 1'b0;
      slew_r     <= 1'b0;
    end
    else if (state_r != ST_RUN)
    begin
      vid_last_r <= voltage_id_code;
      wait_r     <= 2'h0;
      slew_r     <= 1'b0;
    end
    else if (tk.sub_tick)
    begin
      vid_last_r <= voltage_id_code; // see R01
      if (vid_change && (diff_up || diff_dn))
      begin
        wait_r   <= HALF_WAIT; // see R02
        dir_up_r <= diff_up;
        slew_r   <= 1'b0;
      end
      else if (wait_r != 2'h0)
      begin
        wait_r <= wait_r - 2'h1;
        if (wait_r == 2'h1)
          slew_r <= same_dir; // see R03 see R04
      end
      else
        slew_r <= slew_r && same_dir; // see R04
    end
  end

  // ------------------------------------------------------------
  // Outputs toward the power stage
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hiz_r <= 1'b1;
    else if ((state_nxt == ST_OFF) || (state_nxt == ST_DELAY))
      hiz_r <= 1'b1; // see R06
    else if ((state_r == ST_RAMP) && output_reached)
      hiz_r <= 1'b0; // see R16
    else if (state_nxt == ST_RUN)
      hiz_r <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_ok_flag_r <= 1'b0;
      ovsd_r  <= 1'b1;
    end
    else
    begin
      output_ok_flag_r <= (state_nxt == ST_RUN) && output_in_window; // see R21 see R23
      ovsd_r  <= (state_nxt == ST_OFF); // see R12
    end
  end

  // Overvoltage latch: cleared only by dropping an enable pin; set wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ovl_r <= 1'b0;
    else if (ov_trip_event)
      ovl_r <= 1'b1;
    else if (!pins_ok)
      ovl_r <= 1'b0; // see R13
  end

  assign pwm_hiz           = hiz_r;
  assign ref_level         = ref_r;
  assign sense_offset      = ofs_r;
  assign ov_shutdown_level = ovsd_r;
  assign output_ok_flag    = output_ok_flag_r;

  // ------------------------------------------------------------
  // AHB-Lite register slave
  // ------------------------------------------------------------
  wire logic       bus_go   = hsel && hready && htrans[1];
  wire logic [7:0] rd_addr  = haddr[7:0];
  wire logic [31:0] stat_w  = {26'h0, ovl_r, output_ok_flag_r, hiz_r, state_r};
  wire logic [31:0] level_w = {8'h00, 4'h0, ofs_r, target, ref_r};
  wire logic [31:0] rd_mux  = (rd_addr == ADDR_DIV)   ? {16'h0000, sub_div_r} :
                              (rd_addr == ADDR_STAT)  ? stat_w :
                              (rd_addr == ADDR_LEVEL) ? level_w : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= bus_go && hwrite;
      if (bus_go)
        wr_addr_r <= rd_addr;
      if (bus_go && !hwrite)
        hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sub_div_r <= SUB_DIV_RST;
    else if (wr_pend_r && (wr_addr_r == ADDR_DIV))
      sub_div_r <= hwdata[15:0]; // see R24
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_shutdown_hiz: assert property ((state_r == ST_OFF) |-> pwm_hiz) // see R06
    else $error("PWM driven while shut down.");

  chk_supply_gate: assert property (!supply_valid_flag |=> (state_r == ST_OFF)) // see R07
    else $error("Running without valid supply.");

  chk_thresh_gate: assert property (!threshold_enable_input |=> (state_r == ST_OFF)) // see R08
    else $error("Running with threshold enable low.");

  chk_logic_gate: assert property (!logic_level_enable |=> (state_r == ST_OFF)) // see R09
    else $error("Running with logic enable low.");

  chk_noload_hold: assert property (((state_r == ST_OFF) && no_load) |=> (state_r == ST_OFF)) // see R10
    else $error("Left shutdown on a no-load code.");

  chk_immediate_start: assert property ( // see R14
    ((state_r == ST_OFF) && enable_ok && !no_load) |=> (state_r == ST_DELAY) && (ref_r == 8'h00))
    else $error("Soft-start did not begin at once.");

  chk_delay_length: assert property ( // see R17
    ((state_r == ST_DELAY) && tk.cyc_tick && (cnt_r == DELAY_CYC - 11'h001) && enable_ok
     && !no_load) |=> (state_r == ST_RAMP) && (ofs_r == OFS_INIT))
    else $error("Idle delay length wrong.");

  chk_ovl_holds_off: assert property ((ovl_r && pins_ok) |=> (state_r == ST_OFF)) // see R13
    else $error("Overvoltage latch released by code change.");

  chk_output_ok_flag_off: assert property ((state_r != ST_RUN) |-> !output_ok_flag) // see R23
    else $error("Output ok high outside regulation.");

  chk_run_step_size: assert property ( // see R02
    ((state_r == ST_RUN) && $past(state_r == ST_RUN)) |->
      ((ref_r == $past(ref_r)) || (ref_r == $past(ref_r) + 8'h01)
       || (ref_r + 8'h01 == $past(ref_r))))
    else $error("Reference moved more than one step.");

  chk_noload_delay: assert property ( // see R12
    ((state_r == ST_RUN) && no_load && enable_ok) |=> !ov_shutdown_level [*2])
    else $error("Shutdown level switched too early.");

endmodule

// *** test/vrs_cpu_model.sv ***
// Processor-side model that drives the voltage identification code.
`timescale 1ns/10ps
module vrs_cpu_model
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [5:0] goal,
  input  wire logic       jump,
  input  wire logic [7:0] gap,
  output logic [5:0]      voltage_id_code
);
  logic [7:0] wait_r;

  function automatic int level_of(input logic [5:0] c);
    return (c <= 6'h14) ? 32'h57 - 32'(c) : 32'h95 - 32'(c);
  endfunction

  // A well-behaved processor moves one level and then pauses for gap cycles.
  // Jump mode is the discouraged multi-step change, used only when commanded.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_r          <= 8'h00;
      voltage_id_code <= 6'h00;
    end
    else if (jump)
      voltage_id_code <= goal;
    else if (wait_r != 8'h00)
      wait_r <= wait_r - 8'h01;
    else if (voltage_id_code != goal)
    begin
      wait_r <= gap;
      if (level_of(goal) > level_of(voltage_id_code))
        voltage_id_code <= (voltage_id_code == 6'h00) ? 6'h3D : voltage_id_code - 6'h01;
      else
        voltage_id_code <= (voltage_id_code == 6'h3D) ? 6'h00 : voltage_id_code + 6'h01;
    end
  end
endmodule

// *** test/vid_reference_sequencer_tb.sv ***
// Self-checking bench for the reference sequencer.
`timescale 1ns/10ps
module vid_reference_sequencer_tb;
  import vrs_pkg::*;

  typedef struct packed
  {
    logic [2:0]  en;
    logic [5:0]  code;
    logic [7:0]  addr;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] ex;
  } vrs_row_type;

  // Enables are supply, threshold, logic; status 0x08 means off with PWM high-impedance.
  localparam vrs_row_type ROWS [15] = '{
    '{3'h0, 6'h00, 8'h00, 1'b0, 32'h0, 32'h1}, '{3'h3, 6'h00, 8'h04, 1'b0, 32'h0, 32'h8},
    '{3'h5, 6'h00, 8'h04, 1'b0, 32'h0, 32'h8}, '{3'h6, 6'h00, 8'h04, 1'b0, 32'h0, 32'h8},
    '{3'h7, 6'h3F, 8'h04, 1'b0, 32'h0, 32'h8}, '{3'h7, 6'h3E, 8'h04, 1'b0, 32'h0, 32'h8},
    '{3'h0, 6'h14, 8'h04, 1'b1, 32'hFF, 32'h0}, '{3'h0, 6'h14, 8'h04, 1'b0, 32'h0, 32'h8},
    '{3'h0, 6'h14, 8'h0C, 1'b0, 32'h0, 32'h0}, '{3'h0, 6'h14, 8'h08, 1'b0, 32'h0, 32'h4300},
    '{3'h0, 6'h15, 8'h08, 1'b0, 32'h0, 32'h8000}, '{3'h0, 6'h3D, 8'h08, 1'b0, 32'h0, 32'h5800},
    '{3'h0, 6'h14, 8'h00, 1'b1, 32'h2, 32'h0}, '{3'h0, 6'h14, 8'h00, 1'b0, 32'h0, 32'h2},
    '{3'h0, 6'h14, 8'h00, 1'b1, 32'h1, 32'h0}};

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, jump, mon;
  logic        supply_valid_flag, threshold_enable_input, logic_level_enable;
  logic        output_reached, output_in_window, ov_trip_event;
  logic        pwm_hiz, ov_shutdown_level, output_ok_flag;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  sense_offset;
  logic [5:0]  goal, voltage_id_code;
  logic [7:0]  ref_level, prv, gap;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          error_cnt, samples_checked, cyc, t0;

  vrs_sequencer #(.SUB_DIV_RST(16'h0001)) i_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .supply_valid_flag(supply_valid_flag), .threshold_enable_input(threshold_enable_input),
    .logic_level_enable(logic_level_enable), .voltage_id_code(voltage_id_code),
    .output_reached(output_reached), .output_in_window(output_in_window),
    .ov_trip_event(ov_trip_event), .pwm_hiz(pwm_hiz), .ref_level(ref_level),
    .sense_offset(sense_offset), .ov_shutdown_level(ov_shutdown_level),
    .output_ok_flag(output_ok_flag)
  );

  vrs_cpu_model i_cpu
  (
    .hclk(hclk), .hresetn(hresetn), .goal(goal), .jump(jump), .gap(gap),
    .voltage_id_code(voltage_id_code)
  );

  always #4 hclk = ~hclk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tmo(input int lim);
    if (cyc - t0 >= lim)
    begin
      error_cnt++;
      $display("[ERR] wait_bound expected below %0d seen %0d", lim, cyc - t0);
      conclude();
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge hclk);
  endtask

  // The master holds each phase until it samples hready high; no latency is assumed.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    t0 = cyc;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && cyc - t0 < 40) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && cyc - t0 < 40) @(posedge hclk);
    q = hrdata;
    tmo(40);
  endtask

  task automatic rst_chk();
    chk("pwm_hiz", 32'(pwm_hiz), 32'h1);
    chk("ok", 32'(output_ok_flag), 32'h0);
    chk("ref", 32'(ref_level), 32'h0);
    chk("ovl", {31'h0, ov_shutdown_level}, 32'h1);
    chk("bus", {sense_offset, hrdata[25:0], hresp, hreadyout}, 32'h1);
  endtask

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (mon && ref_level !== prv)
      chk("ramp_step", 32'(ref_level - prv), (prv < 8'h28) ? 32'h2 : 32'h1);
    prv <= ref_level;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {hclk, hsel, hwrite, mon, ov_trip_event, output_reached, output_in_window} = 7'h00;
    {supply_valid_flag, threshold_enable_input, logic_level_enable} = 3'h0;
    {hresetn, jump, htrans, hsize, goal, gap} = {1'b0, 1'b1, 2'h0, 3'h2, 6'h00, 8'h00};
    {haddr, hwdata, error_cnt, samples_checked, cyc, t0, prv} = '0;
    wt(3);
    rst_chk();
    wt(3);
    hresetn <= 1'b1;
    wt(1);
    foreach (ROWS[i])
    begin
      {supply_valid_flag, threshold_enable_input, logic_level_enable} <= 3'h0;
      goal <= ROWS[i].code;
      wt(4);
      {supply_valid_flag, threshold_enable_input, logic_level_enable} <= ROWS[i].en;
      wt(8);
      bus(ROWS[i].addr, ROWS[i].wr, ROWS[i].wd, rd);
      if (!ROWS[i].wr)
        chk("row_rdata", rd, ROWS[i].ex);
    end
    // Soft-start toward code 0x14, level 0x43; the output is reached part way up.
    output_in_window <= 1'b1;
    {supply_valid_flag, threshold_enable_input, logic_level_enable} <= 3'h7;
    mon <= 1'b1;
    t0 = cyc;
    wt(3);
    chk("offset_start", 32'(sense_offset), 32'h8);
    bus(8'h04, 1'b0, 32'h0, rd);
    chk("state_delay", rd, 32'h9);
    t0 = cyc - 6;
    while (ref_level < 8'h14 && cyc - t0 < 9000) @(posedge hclk);
    tmo(9000);
    chk("hiz_ramp", 32'(pwm_hiz), 32'h1);
    chk("ok_ramp", 32'(output_ok_flag), 32'h0);
    chk("offset_mid", 32'(sense_offset >= 4'h3 && sense_offset <= 4'h5), 32'h1);
    output_reached <= 1'b1;
    wt(3);
    chk("hiz_reached", 32'(pwm_hiz), 32'h0);
    while (ref_level !== 8'h43 && cyc - t0 < 9000) @(posedge hclk);
    tmo(9000);
    chk("ss_time", 32'(cyc - t0 >= 6720 && cyc - t0 <= 6912), 32'h1);
    mon <= 1'b0;
    wt(4);
    chk("ok_run", {sense_offset, ov_shutdown_level, output_ok_flag}, 32'h1);
    output_in_window <= 1'b0;
    wt(3);
    chk("ok_window", 32'(output_ok_flag), 32'h0);
    output_in_window <= 1'b1;
    // Code tracking: one step, a jump of five, then a change that reverses inside the wait.
    jump <= 1'b0;
    gap  <= 8'hC8;
    goal <= 6'h13;
    t0 = cyc;
    while (voltage_id_code !== 6'h13 && cyc - t0 < 20) @(posedge hclk);
    tmo(20);
    wt(1);
    chk("step_wait", 32'(ref_level), 32'h43);
    wt(12);
    chk("step_one", 32'(ref_level), 32'h44);
    jump <= 1'b1;
    goal <= 6'h0E;
    wt(3);
    chk("jump_wait", 32'(ref_level), 32'h44);
    wt(20);
    chk("jump_done", 32'(ref_level), 32'h49);
    goal <= 6'h0D;
    wt(2);
    goal <= 6'h0E;
    wt(1);
    chk("reverse_mid", 32'(ref_level), 32'h49);
    wt(20);
    chk("reverse_end", 32'(ref_level), 32'h49);
    // No-load code: two switching cycles of grace, then shutdown and a fresh start.
    goal <= 6'h3F;
    wt(8);
    chk("noload_wait", {pwm_hiz, ov_shutdown_level}, 32'h0);
    wt(20);
    chk("noload_off", {pwm_hiz, ov_shutdown_level, output_ok_flag}, 32'h6);
    goal <= 6'h14;
    wt(4);
    bus(8'h04, 1'b0, 32'h0, rd);
    chk("restart", rd & 32'h7, 32'h1);
    t0 = cyc;
    while (ref_level !== 8'h43 && cyc - t0 < 9000) @(posedge hclk);
    tmo(9000);
    // An overvoltage latch survives no-load codes and clears only with an enable pin.
    ov_trip_event <= 1'b1;
    wt(1);
    ov_trip_event <= 1'b0;
    goal <= 6'h3F;
    wt(30);
    goal <= 6'h14;
    wt(30);
    bus(8'h04, 1'b0, 32'h0, rd);
    chk("latch_held", rd & 32'h27, 32'h20);
    logic_level_enable <= 1'b0;
    wt(4);
    logic_level_enable <= 1'b1;
    wt(4);
    bus(8'h04, 1'b0, 32'h0, rd);
    chk("latch_clear", rd & 32'h7, 32'h1);
    hresetn <= 1'b0;
    wt(3);
    rst_chk();
    conclude();
  end
endmodule
